/* trpt_top.sv */
// Transceiver block reset, power-down and test-status control with APB registers
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

// How it works
// - Block power-down switches off coding, serial, clock-recovery and PCIe circuits.
// - Block power-down leaves the reference clock buffers running.
// - Transmit-coding reset holds all transmit coding logic in reset.
// - Receive-analog reset resets the receiver analog circuitry.
// - Receive-coding reset holds all receive coding logic in reset.
// - Reconfiguration clock also runs offset cancellation except in PIPE mode.
// - BIST done rises on a full pattern or error; cleared by receive-coding reset.
// - PRBS done rises on a full pattern; cleared by receive-coding reset.
// - BIST error flag stays set until receive-coding reset.
// - PRBS error flag stays high at least three recovered clock cycles.
// - PRBS error flag drops when the next sequence is error free.
module trpt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blk_powerdown,
  input wire logic tx_coding_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_coding_reset,
  input wire logic rx_serial_bit,
  output trpt_pkg::trpt_power_t power_on,
  output trpt_pkg::trpt_hold_t hold,
  output logic offset_cancel_busy,
  output logic test_done,
  output logic test_err,
  output logic irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    trpt_pkg::trpt_ctrl_t ctrl;
    trpt_pkg::trpt_irq_t int_stat;
    trpt_pkg::trpt_irq_t int_mask;
    trpt_pkg::trpt_irq_t prev;
    logic [3:0] rx_div;
    logic [3:0] rc_div;
    logic [7:0] oc_cnt;
    logic [31:0] rdata;
    trpt_pkg::trpt_irq_t rd_clr;
    trpt_pkg::trpt_power_t power;
    trpt_pkg::trpt_hold_t hold;
    logic irq;
  } trpt_state_t;

  trpt_state_t s_q;
  trpt_state_t s_d;

  logic pd_eff;
  logic tx_rst_eff;
  logic rxa_rst_eff;
  logic rxc_rst_eff;
  logic rx_tick;
  logic rc_tick;
  logic vf_done;
  logic vf_err;
  logic setup;
  logic access;
  trpt_pkg::trpt_mode_t mode;
  trpt_pkg::trpt_irq_t events;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic trpt_pkg::trpt_mode_t trpt_decode_mode(input logic [1:0] f);
    case (f)
      2'h1: trpt_decode_mode = trpt_pkg::TRPT_MODE_BIST;
      2'h2: trpt_decode_mode = trpt_pkg::TRPT_MODE_PRBS;
      2'h3: trpt_decode_mode = trpt_pkg::TRPT_MODE_PIPE;
      default: trpt_decode_mode = trpt_pkg::TRPT_MODE_NORMAL;
    endcase
  endfunction

  function automatic logic trpt_mapped(input logic [11:0] a);
    trpt_mapped = (a == trpt_pkg::TRPT_CTRL_OFS) || (a == trpt_pkg::TRPT_STATUS_OFS) ||
                  (a == trpt_pkg::TRPT_INT_STAT_OFS) || (a == trpt_pkg::TRPT_INT_MASK_OFS);
  endfunction

  // ------------------------------------------------------------------
  // Effective controls: synchronised pin OR register bit
  // ------------------------------------------------------------------
  assign pd_eff = s_q.sync2[0] | s_q.ctrl.powerdown;
  assign tx_rst_eff = s_q.sync2[1] | s_q.ctrl.tx_coding_rst;
  assign rxa_rst_eff = s_q.sync2[2] | s_q.ctrl.rx_analog_rst;
  assign rxc_rst_eff = s_q.sync2[3] | s_q.ctrl.rx_coding_rst;
  assign mode = trpt_decode_mode(s_q.ctrl.mode);
  assign rx_tick = (s_q.rx_div == 4'h0);
  assign rc_tick = (s_q.rc_div == 4'h0);
  assign setup = psel & ~penable;
  assign access = psel & penable;

  // ------------------------------------------------------------------
  // Pattern verifier
  // ------------------------------------------------------------------
  trpt_verifier u_verifier (
    .pclk(pclk),
    .presetn(presetn),
    .rx_tick(rx_tick),
    .clr(s_q.hold.rx_coding),
    .mode(mode),
    .rx_bit(s_q.sync2[4]),
    .done(vf_done),
    .err(vf_err)
  );

  assign events = {pd_eff & ~s_q.prev.powerdown, vf_err & ~s_q.prev.err,
                   vf_done & ~s_q.prev.done};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync1 = {rx_serial_bit, rx_coding_reset, rx_analog_reset, tx_coding_reset,
                 blk_powerdown};
    s_d.sync2 = s_q.sync1;

    // Recovered parallel clock and reconfiguration clock enables
    s_d.rx_div = rx_tick ? trpt_pkg::TRPT_RX_DIV - 4'h1 : s_q.rx_div - 4'h1;
    s_d.rc_div = rc_tick ? trpt_pkg::TRPT_RECFG_DIV - 4'h1 : s_q.rc_div - 4'h1;

    // Power enables of the block's modules
    s_d.power.coding = ~pd_eff;
    s_d.power.serial_if = ~pd_eff;
    s_d.power.cdr = ~pd_eff;
    s_d.power.pcie = ~pd_eff;
    s_d.power.refclk_buf = 1'b1;

    // Power-down also holds the powered-off coding logic and the receive analog circuitry in reset
    s_d.hold.tx_coding = tx_rst_eff | pd_eff;
    s_d.hold.rx_analog = rxa_rst_eff | pd_eff;
    s_d.hold.rx_coding = rxc_rst_eff | pd_eff;

    // Offset cancellation restarts after analog reset, counted on reconfig ticks
    if (s_q.hold.rx_analog || mode == trpt_pkg::TRPT_MODE_PIPE) begin
      s_d.oc_cnt = (mode == trpt_pkg::TRPT_MODE_PIPE) ? 8'h00 : trpt_pkg::TRPT_OC_TICKS;
    end else if (rc_tick && s_q.oc_cnt != 8'h00) begin
      s_d.oc_cnt = s_q.oc_cnt - 8'h01;
    end

    // Register bus: read data captured in the setup cycle
    s_d.prev.done = vf_done;
    s_d.prev.err = vf_err;
    s_d.prev.powerdown = pd_eff;
    if (setup) begin
      s_d.rdata = 32'h0000_0000;
      s_d.rd_clr = 3'h0;
      if (!pwrite) begin
        case (paddr)
          trpt_pkg::TRPT_CTRL_OFS: begin
            s_d.rdata = {25'h000_0000, s_q.ctrl};
          end
          trpt_pkg::TRPT_STATUS_OFS: begin
            s_d.rdata = {25'h000_0000, s_q.oc_cnt != 8'h00, vf_err, vf_done,
                         s_q.hold.rx_coding, s_q.hold.rx_analog, s_q.hold.tx_coding,
                         pd_eff};
          end
          trpt_pkg::TRPT_INT_STAT_OFS: begin
            s_d.rdata = {29'h0000_0000, s_q.int_stat};
            s_d.rd_clr = s_q.int_stat;
          end
          trpt_pkg::TRPT_INT_MASK_OFS: begin
            s_d.rdata = {29'h0000_0000, s_q.int_mask};
          end
          default: begin
            s_d.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Sticky status: read clears what was returned, a new event wins
    if (access && !pwrite && paddr == trpt_pkg::TRPT_INT_STAT_OFS) begin
      s_d.int_stat = s_q.int_stat & ~s_q.rd_clr;
    end
    s_d.int_stat = s_d.int_stat | events;

    if (access && pwrite) begin
      case (paddr)
        trpt_pkg::TRPT_CTRL_OFS: begin
          s_d.ctrl = pwdata[6:0];
        end
        trpt_pkg::TRPT_INT_MASK_OFS: begin
          s_d.int_mask = pwdata[2:0];
        end
        default: begin
          s_d.ctrl = s_q.ctrl;
        end
      endcase
    end

    s_d.irq = |(s_d.int_stat & s_d.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{sync1: 5'h00, sync2: 5'h00, ctrl: trpt_pkg::TRPT_CTRL_RST,
               int_stat: 3'h0, int_mask: trpt_pkg::TRPT_INT_MASK_RST, prev: 3'h0,
               rx_div: 4'h0, rc_div: 4'h0, oc_cnt: 8'h00, rdata: 32'h0000_0000,
               rd_clr: 3'h0, power: 5'h10, hold: 3'h7, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = s_q.rdata;
  assign pready = access;
  assign pslverr = access & ~trpt_mapped(paddr);
  assign power_on = s_q.power;
  assign hold = s_q.hold;
  assign offset_cancel_busy = (s_q.oc_cnt != 8'h00);
  assign test_done = vf_done;
  assign test_err = vf_err;
  assign irq = s_q.irq;

endmodule

/* trpt_pkg.sv */
// Package: register map, field layouts, modes and timing counts of the reset/test block
package trpt_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] TRPT_CTRL_OFS = 12'h000;
  localparam logic [11:0] TRPT_STATUS_OFS = 12'h004;
  localparam logic [11:0] TRPT_INT_STAT_OFS = 12'h008;
  localparam logic [11:0] TRPT_INT_MASK_OFS = 12'h00C;

  localparam logic [6:0] TRPT_CTRL_RST = 7'h00;
  localparam logic [2:0] TRPT_INT_MASK_RST = 3'h0;

  // ------------------------------------------------------------------
  // Timing counts
  // ------------------------------------------------------------------
  // Recovered parallel clock and reconfiguration clock as enables of pclk
  localparam logic [3:0] TRPT_RX_DIV = 4'h4;
  localparam logic [3:0] TRPT_RECFG_DIV = 4'h2;
  // Reconfiguration ticks spent on offset cancellation after analog reset
  localparam logic [7:0] TRPT_OC_TICKS = 8'h20;
  // PRBS7 pattern: seed bits and cycle length
  localparam logic [6:0] TRPT_SEED_LAST = 7'h06;
  localparam logic [6:0] TRPT_CYCLE_LAST = 7'h7E;
  // Least width of the PRBS error flag in recovered-clock cycles
  localparam logic [1:0] TRPT_PRBS_ERR_HOLD = 2'h3;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    TRPT_MODE_NORMAL = 4'b0001,
    TRPT_MODE_BIST = 4'b0010,
    TRPT_MODE_PRBS = 4'b0100,
    TRPT_MODE_PIPE = 4'b1000
  } trpt_mode_t;

  // Control register: mode field 00 normal, 01 BIST, 10 PRBS, 11 PIPE
  typedef struct packed {
    logic [1:0] mode;
    logic rx_coding_rst;
    logic rx_analog_rst;
    logic tx_coding_rst;
    logic powerdown;
    logic spare;
  } trpt_ctrl_t;

  // Interrupt status / mask layout
  typedef struct packed {
    logic powerdown;
    logic err;
    logic done;
  } trpt_irq_t;

  // Power enables of the block's modules, high while the module is on
  typedef struct packed {
    logic refclk_buf;
    logic pcie;
    logic cdr;
    logic serial_if;
    logic coding;
  } trpt_power_t;

  // Resets the block applies to its own circuits, high while held
  typedef struct packed {
    logic rx_coding;
    logic rx_analog;
    logic tx_coding;
  } trpt_hold_t;

endpackage

/* trpt_verifier.sv */
// BIST / PRBS7 pattern verifier producing the done and error flags
`timescale 1ns/1ps

module trpt_verifier (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_tick,
  input wire logic clr,
  input wire trpt_pkg::trpt_mode_t mode,
  input wire logic rx_bit,
  output logic done,
  output logic err
);

  typedef enum logic [2:0] {
    TRPT_VF_SEED = 3'b001,
    TRPT_VF_RUN = 3'b010,
    TRPT_VF_STOP = 3'b100
  } trpt_vf_state_t;

  typedef struct packed {
    trpt_vf_state_t st;
    logic [6:0] lfsr;
    logic [6:0] cnt;
    logic [1:0] hold;
    logic seq_err;
    logic done;
    logic err;
  } trpt_vf_t;

  trpt_vf_t s_q;
  trpt_vf_t s_d;
  logic pred;
  logic bad;
  logic test_on;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    pred = s_q.lfsr[6] ^ s_q.lfsr[5];
    bad = rx_bit != pred;
    test_on = (mode == trpt_pkg::TRPT_MODE_BIST) || (mode == trpt_pkg::TRPT_MODE_PRBS);
    if (clr || !test_on) begin
      // Receive-coding reset wipes both flags
      s_d.st = TRPT_VF_SEED;
      s_d.cnt = 7'h00;
      s_d.hold = 2'h0;
      s_d.seq_err = 1'b0;
      if (clr) begin
        s_d.done = 1'b0;
        s_d.err = 1'b0;
      end
    end else if (rx_tick) begin
      if (s_q.hold != 2'h0) begin
        s_d.hold = s_q.hold - 2'h1;
      end
      case (s_q.st)
        TRPT_VF_SEED: begin
          s_d.lfsr = {s_q.lfsr[5:0], rx_bit};
          s_d.cnt = s_q.cnt + 7'h01;
          if (s_q.cnt == trpt_pkg::TRPT_SEED_LAST) begin
            s_d.st = TRPT_VF_RUN;
            s_d.cnt = 7'h00;
          end
        end
        TRPT_VF_RUN: begin
          s_d.lfsr = {s_q.lfsr[5:0], pred};
          s_d.cnt = s_q.cnt + 7'h01;
          if (mode == trpt_pkg::TRPT_MODE_BIST) begin
            if (bad) begin
              // Error ends the BIST run with both flags up
              s_d.err = 1'b1;
              s_d.done = 1'b1;
              s_d.st = TRPT_VF_STOP;
            end else if (s_q.cnt == trpt_pkg::TRPT_CYCLE_LAST) begin
              s_d.done = 1'b1;
              s_d.st = TRPT_VF_STOP;
            end
          end else begin
            if (bad) begin
              // Error flag held at least three recovered cycles
              s_d.err = 1'b1;
              s_d.seq_err = 1'b1;
              s_d.hold = trpt_pkg::TRPT_PRBS_ERR_HOLD - 2'h1;
            end
            if (s_q.cnt == trpt_pkg::TRPT_CYCLE_LAST) begin
              s_d.done = 1'b1;
              s_d.cnt = 7'h00;
              s_d.seq_err = 1'b0;
              // A clean sequence drops the error flag
              if (!s_q.seq_err && !bad && s_q.hold == 2'h0) begin
                s_d.err = 1'b0;
              end
            end
          end
        end
        TRPT_VF_STOP: begin
          s_d.st = TRPT_VF_STOP;
        end
        default: begin
          s_d.st = TRPT_VF_SEED;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: TRPT_VF_SEED, lfsr: 7'h00, cnt: 7'h00, hold: 2'h0,
               seq_err: 1'b0, done: 1'b0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign err = s_q.err;

endmodule

/* trpt_fabric.sv */
// Partner model: fabric reset controller, PRBS7 source and flag synchroniser
`timescale 1ns/1ps

module trpt_fabric (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] req,
  input wire logic inject,
  input wire logic test_done,
  input wire logic test_err,
  output logic [2:0] rst_pins,
  output logic rx_serial_bit,
  output logic [1:0] flags_sync
);
  logic [6:0] lfsr_q;
  logic [1:0] div_q, sync_q;
  logic [3:0] cnt_q;
  logic inv_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= 7'h5A;
      div_q <= 2'h0;
      cnt_q <= 4'h0;
      inv_q <= 1'b0;
      rst_pins <= 3'h0;
      rx_serial_bit <= 1'b0;
      sync_q <= 2'h0;
      flags_sync <= 2'h0;
    end else begin
      // A new reset pulse stands 9 pclk, just over two recovered-clock cycles
      cnt_q <= |(req & ~rst_pins) ? 4'h8 : cnt_q - {3'h0, |cnt_q};
      rst_pins <= req | (|cnt_q ? rst_pins : 3'h0);
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
        rx_serial_bit <= lfsr_q[6] ^ inv_q;
        inv_q <= inject;
      end else if (inject) begin
        inv_q <= 1'b1;
      end
      sync_q <= {test_err, test_done};
      flags_sync <= sync_q;
    end
  end
endmodule

/* trpt_chk.sv */
// Checker: concurrent assertions on the ports of the reset/test block
`timescale 1ns/1ps

module trpt_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic blk_powerdown,
  input wire logic tx_coding_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_coding_reset,
  input wire trpt_pkg::trpt_power_t power_on,
  input wire trpt_pkg::trpt_hold_t hold,
  input wire logic offset_cancel_busy,
  input wire logic test_done,
  input wire logic test_err
);
  logic [1:0] mode_q;
  logic [11:0] run_q;

  // Mode field mirror and length of the current error-flag run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      run_q <= 12'h000;
    end else begin
      if (psel && penable && pwrite && paddr == trpt_pkg::TRPT_CTRL_OFS) mode_q <= pwdata[6:5];
      run_q <= !test_err ? 12'h000 : run_q + {11'h000, run_q != 12'hFFF};
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PD_OFF: assert property (blk_powerdown [*4] |-> power_on[3:0] == 4'h0)
    else $error("power-down left a module on");
  AST_REFCLK: assert property (power_on.refclk_buf)
    else $error("reference clock buffer switched off");
  AST_TX_HOLD: assert property (tx_coding_reset [*4] |-> hold.tx_coding)
    else $error("transmit coding not held");
  AST_RXA_HOLD: assert property (rx_analog_reset [*4] |-> hold.rx_analog)
    else $error("receive analog not held");
  AST_RXC_HOLD: assert property (rx_coding_reset [*4] |-> hold.rx_coding)
    else $error("receive coding not held");
  AST_OC_PIPE: assert property ((mode_q == 2'h3) [*3] |-> !offset_cancel_busy)
    else $error("offset cancel busy in PIPE mode");
  AST_OC_START: assert property (
    $fell(hold.rx_analog) && mode_q != 2'h3 |-> ##[0:3] offset_cancel_busy)
    else $error("offset cancel did not start");
  AST_DONE_KEEP: assert property (
    test_done && !hold.rx_coding |=> test_done || hold.rx_coding)
    else $error("done flag dropped without reset");
  AST_CLEAR: assert property (hold.rx_coding [*3] |-> !test_done && !test_err)
    else $error("flags not cleared by receive reset");
  AST_BIST_ERR: assert property (
    mode_q == 2'h1 && test_err && !hold.rx_coding |=> test_err || hold.rx_coding)
    else $error("self-test error flag dropped");
  AST_ERR_WIDTH: assert property (
    $fell(test_err) && !hold.rx_coding |-> run_q >= 12'h00C)
    else $error("error flag shorter than three recovered cycles");
  AST_ERR_DROP: assert property (test_err && mode_q == 2'h2 |-> run_q < 12'h4B0)
    else $error("PRBS error flag stuck");
endmodule

bind trpt_top trpt_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .blk_powerdown, .tx_coding_reset, .rx_analog_reset, .rx_coding_reset, .power_on, .hold,
  .offset_cancel_busy, .test_done, .test_err);

/* trpt_top_bench.sv */
// Testbench: directed scenarios for the reset, power-down and test-status block
`timescale 1ns/1ps

module trpt_top_bench;
  logic pclk, presetn, psel, penable, pwrite, blk_powerdown, inject, rerr;
  logic pready, pslverr, offset_cancel_busy, test_done, test_err, irq, rx_serial_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] req, rst_pins;
  logic [1:0] flags_sync;
  trpt_pkg::trpt_power_t power_on;
  trpt_pkg::trpt_hold_t hold;
  int fail_count, total_checks;

  trpt_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .blk_powerdown, .tx_coding_reset(rst_pins[0]), .rx_analog_reset(rst_pins[1]),
    .rx_coding_reset(rst_pins[2]), .rx_serial_bit, .power_on, .hold, .offset_cancel_busy,
    .test_done, .test_err, .irq);
  trpt_fabric fabric (.pclk, .presetn, .req, .inject, .test_done, .test_err, .rst_pins,
    .rx_serial_bit, .flags_sync);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      stop_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset request and error injection go through the partner for one edge
  task automatic drive(input logic [2:0] r, input logic e);
    @(posedge pclk);
    req <= r;
    inject <= e;
    @(posedge pclk);
    req <= 3'h0;
    inject <= 1'b0;
  endtask

  task automatic wait_for(input int sel, input logic val, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(posedge pclk);
      s = (sel == 0) ? test_done : (sel == 1) ? test_err : offset_cancel_busy;
      if (s === val) return;
    end
    fail_count++;
    stop_test();
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_regs_irq();
    apb(1'b0, trpt_pkg::TRPT_INT_MASK_OFS, 32'h0);
    check(rdata, 32'(trpt_pkg::TRPT_INT_MASK_RST));
    apb(1'b1, trpt_pkg::TRPT_INT_MASK_OFS, 32'h4);
    apb(1'b0, 12'h010, 32'h0);
    check(32'(rerr), 32'h1);
    @(posedge pclk);
    blk_powerdown <= 1'b1;
    cyc(6);
    check(32'(power_on), 32'h10);
    check(32'(irq), 32'h1);
    apb(1'b0, trpt_pkg::TRPT_INT_STAT_OFS, 32'h0);
    check(rdata, 32'h4);
    cyc(2);
    check(32'(irq), 32'h0);
    blk_powerdown <= 1'b0;
    cyc(6);
    check(32'(power_on), 32'h1F);
    $display("test_regs_irq finished");
  endtask

  task automatic test_resets();
    for (int i = 0; i < 3; i++) begin
      drive(3'h1 << i, 1'b0);
      cyc(4);
      check(32'(hold), 32'h1 << i);
      cyc(10);
      check(32'(hold), 32'h0);
    end
    check(32'(offset_cancel_busy), 32'h1);
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h60);
    drive(3'h2, 1'b0);
    cyc(20);
    check(32'(offset_cancel_busy), 32'h0);
    $display("test_resets finished");
  endtask

  // Register-driven holds and power-down, seen on the pins and in STATUS
  task automatic test_ctrl_regs();
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h64);
    apb(1'b0, trpt_pkg::TRPT_CTRL_OFS, 32'h0);
    check(rdata, 32'h64);
    check(32'(hold), 32'h1);
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h62);
    apb(1'b0, trpt_pkg::TRPT_STATUS_OFS, 32'h0);
    check(rdata, 32'hF);
    check(32'(power_on), 32'h10);
    apb(1'b0, trpt_pkg::TRPT_INT_STAT_OFS, 32'h0);
    check(rdata, 32'h4);
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h60);
    cyc(2);
    check(32'({power_on, hold}), 32'hF8);
    $display("test_ctrl_regs finished");
  endtask

  task automatic test_bist();
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h20);
    drive(3'h4, 1'b0);
    cyc(100);
    drive(3'h0, 1'b1);
    wait_for(1, 1'b1, 40);
    check(32'(test_done), 32'h1);
    cyc(700);
    check(32'({test_done, test_err}), 32'h3);
    drive(3'h4, 1'b0);
    cyc(6);
    check(32'({test_done, test_err}), 32'h0);
    wait_for(0, 1'b1, 800);
    check(32'(test_err), 32'h0);
    $display("test_bist finished");
  endtask

  task automatic test_prbs();
    apb(1'b1, trpt_pkg::TRPT_CTRL_OFS, 32'h40);
    drive(3'h4, 1'b0);
    cyc(100);
    drive(3'h0, 1'b1);
    wait_for(1, 1'b1, 40);
    cyc(11);
    check(32'(test_err), 32'h1);
    wait_for(1, 1'b0, 1300);
    check(32'(test_done), 32'h1);
    cyc(3);
    check(32'(flags_sync), 32'h1);
    apb(1'b0, trpt_pkg::TRPT_INT_STAT_OFS, 32'h0);
    check(rdata, 32'h3);
    drive(3'h4, 1'b0);
    cyc(6);
    check(32'(test_done), 32'h0);
    $display("test_prbs finished");
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, blk_powerdown, inject} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    req = 3'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    test_regs_irq();
    test_resets();
    test_ctrl_regs();
    test_bist();
    test_prbs();
    stop_test();
  end
endmodule
